// ==== src/dtc_decoder.sv ====
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - byte 0 must be start mark
// - message id echoed in status
// - hard disk: controller to target, drive lun
// - floppy drives 4-7 pick one select
// - tape on drive 4, drive 5 refused
// - five command types decoded
// - function with type picks operation
// - block index split per medium
// - modifier zero becomes 3e
// - last byte must be end mark
// - no interrupt for configuration answers
// - interrupt per flag or status, vector
// - configuration packet layout
// - attribute bit 7 selects protocol
// - self-test stages, diagnostics if present
// - one status after all test stages
// - self-test packet layout
// - posted flag set by host, cleared
// - extended protocol writes ack or nak
module dtc_decoder #(
  parameter int FD_SPT_LOG2  = 4,
  parameter int TP_SPS_LOG2  = 5,
  parameter int TP_SEGS_LOG2 = 7
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic      [31:0] o_prdata,
  output logic             o_pslverr,
  // backplane interrupt
  input  wire logic        i_iack,
  output logic             o_irq,
  output logic      [7:0]  o_irq_vector,
  // drive interface
  input  wire logic        i_tape_fitted,
  output logic      [3:0]  o_floppy_drive_select_n,
  output logic             o_side_select_n,
  output logic      [2:0]  o_disk_target,
  output logic             o_disk_lun,
  // decoded operation
  output logic             o_op_start,
  output logic      [7:0]  o_op_type,
  output logic      [7:0]  o_op_func,
  output logic      [15:0] o_op_count,
  output logic      [15:0] o_op_block_size,
  output logic      [7:0]  o_op_am,
  output logic      [23:0] o_op_addr,
  output logic      [20:0] o_disk_sector,
  output logic      [7:0]  o_fd_cylinder,
  output logic      [7:0]  o_fd_sector,
  output logic      [7:0]  o_tp_stream,
  output logic      [7:0]  o_tp_segment,
  output logic      [7:0]  o_tp_sector,
  input  wire logic        i_op_done,
  input  wire logic [7:0]  i_op_status,
  // local tester
  output logic             o_test_req,
  output logic      [1:0]  o_test_stage,
  output logic      [7:0]  o_diag_opcode,
  input  wire logic        i_test_done,
  input  wire logic        i_test_pass,
  input  wire logic        i_ctrl_present
);
  import dtc_pkg::*;
  initial begin
    if (FD_SPT_LOG2 < 1 || FD_SPT_LOG2 > 7 || TP_SPS_LOG2 < 1 || TP_SPS_LOG2 > 7
        || TP_SEGS_LOG2 < 1 || TP_SEGS_LOG2 > 8)
      $error("dtc_decoder: geometry out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state so ram read data are ready
  logic [9:0] off;
  logic       acc_wait;
  logic       wr_take;
  logic       unmapped;
  logic       in_cmd_buf;
  logic       in_sts_buf;
  logic [5:0] cmd_idx;
  logic [5:0] sts_idx;
  logic [9:0] cmd_rel;
  logic [9:0] sts_rel;
  assign off        = i_paddr[11:2];
  assign cmd_rel    = off - OFF_CMD_BUF_LO;
  assign sts_rel    = off - OFF_STS_BUF_LO;
  assign cmd_idx    = cmd_rel[6:1];
  assign sts_idx    = sts_rel[6:1];
  assign in_cmd_buf = off >= OFF_CMD_BUF_LO && off <= OFF_CMD_BUF_HI && off[0];
  assign in_sts_buf = off >= OFF_STS_BUF_LO && off <= OFF_STS_BUF_HI && off[0];
  assign unmapped   = !(in_cmd_buf || in_sts_buf || off == OFF_CMD_POSTED
                      || off == OFF_MSG_ACK || off == OFF_STS_POSTED
                      || off == OFF_CMD_CHECK || off == OFF_VECTOR
                      || off == OFF_STATE);
  assign o_pready   = i_psel && i_penable && acc_wait;
  assign o_pslverr  = o_pready && unmapped;
  assign wr_take    = o_pready && i_pwrite && !unmapped;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) acc_wait <= 1'b0;
    else acc_wait <= i_psel && i_penable && !acc_wait;
  end

  //////////////////////////////////////////////////////////////////////////////
  // command channel memory
  dtc_state_t state;
  logic [5:0] rd_idx;
  logic [7:0] ram_q;
  dtc_cmd_ram #(.WIDTH(8), .DEPTH(64)) u_ram (
    .i_clock (i_clock),
    .i_we    (wr_take && in_cmd_buf),
    .i_waddr (cmd_idx),
    .i_wdata (i_pwdata[7:0]),
    .i_raddr (state == ST_FETCH ? rd_idx : cmd_idx),
    .o_rdata (ram_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // channel flags; hardware set beats software clear
  logic [7:0] cmd_posted;
  logic [7:0] msg_ack;
  logic [7:0] sts_posted;
  logic [7:0] cmd_check;
  logic       take_cmd;
  logic       post_sts;
  logic       post_ack;
  logic [7:0] ack_val;
  logic       is_config;
  logic       configured;
  logic       simple_proto;
  logic [7:0] vector;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) cmd_posted <= FLAG_CLEAR;
    else if (wr_take && off == OFF_CMD_POSTED) cmd_posted <= i_pwdata[7:0];
    else if (take_cmd) cmd_posted <= FLAG_CLEAR;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) sts_posted <= FLAG_CLEAR;
    else if (post_sts || (msg_ack == FLAG_NAK && !simple_proto)) sts_posted <= FLAG_POSTED;
    else if (wr_take && off == OFF_STS_POSTED) sts_posted <= i_pwdata[7:0];
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) cmd_check <= FLAG_CLEAR;
    else if (post_ack) cmd_check <= ack_val;
    else if (wr_take && off == OFF_CMD_CHECK) cmd_check <= i_pwdata[7:0];
  end

  // host answer to a status message is consumed the cycle after it lands
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) msg_ack <= FLAG_CLEAR;
    else if (wr_take && off == OFF_MSG_ACK) msg_ack <= i_pwdata[7:0];
    else msg_ack <= FLAG_CLEAR;
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt request, cleared by acknowledge cycle
  logic irq_evt;
  assign irq_evt = (post_sts || post_ack) && !is_config;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) o_irq <= 1'b0;
    else if (irq_evt || (msg_ack == FLAG_NAK && !simple_proto)) o_irq <= 1'b1;
    else if (i_iack) o_irq <= 1'b0;
  end
  assign o_irq_vector = vector;

  //////////////////////////////////////////////////////////////////////////////
  // packet fetch and field capture
  logic       f_vld;
  logic [5:0] f_k;
  logic       bad;
  logic [7:0] msg_id;
  logic [7:0] size;
  logic [7:0] unit;
  logic [7:0] ctype;
  logic [7:0] func;
  logic [15:0] count;
  logic [15:0] bsize;
  logic [7:0] am_raw;
  logic [23:0] maddr;
  logic [23:0] linear_block_index;
  logic       last;
  assign last = f_vld && f_k >= 6'd2 && f_k == size[5:0];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rd_idx <= 6'h00;
      f_vld  <= 1'b0;
      f_k    <= 6'h00;
    end else begin
      f_vld <= state == ST_FETCH && !last;
      f_k   <= rd_idx;
      rd_idx <= state == ST_FETCH ? rd_idx + 6'h01 : 6'h00;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bad <= 1'b0; msg_id <= 8'h00; size <= 8'h00; unit <= 8'h00;
      ctype <= 8'h00; func <= 8'h00; count <= 16'h0000; bsize <= 16'h0000;
      am_raw <= 8'h00; maddr <= 24'h000000; linear_block_index <= 24'h000000;
    end else if (state == ST_IDLE) begin
      bad  <= 1'b0;
      size <= SIZE_MAX;
    end else if (f_vld) begin
      case (f_k)
        6'd0: bad <= bad | (ram_q != BYTE_STX);
        6'd1: msg_id <= ram_q;
        6'd2: begin
          // out-of-range size would never meet the index, so end early
          size <= ((ram_q < SIZE_MIN || ram_q > SIZE_MAX) ? SIZE_MIN : ram_q) - 8'h01;
          bad  <= bad | (ram_q < SIZE_MIN) | (ram_q > SIZE_MAX);
        end
        6'd3: unit <= ram_q;
        6'd4: ctype <= ram_q;
        6'd5: func <= ram_q;
        6'd6: count[15:8] <= ram_q;
        6'd7: count[7:0] <= ram_q;
        6'd8: bsize[15:8] <= ram_q;
        6'd9: bsize[7:0] <= ram_q;
        6'd10: if (size == SIZE_VERIFY - 8'h01) linear_block_index <= 24'h000000; else am_raw <= ram_q;
        6'd11: if (size == SIZE_VERIFY - 8'h01) linear_block_index[23:16] <= ram_q; else maddr[23:16] <= ram_q;
        6'd12: if (size == SIZE_VERIFY - 8'h01) linear_block_index[15:8] <= ram_q; else maddr[15:8] <= ram_q;
        6'd13: if (size == SIZE_VERIFY - 8'h01) linear_block_index[7:0] <= ram_q; else maddr[7:0] <= ram_q;
        6'd17: linear_block_index[23:16] <= ram_q;
        6'd18: linear_block_index[15:8] <= ram_q;
        6'd19: linear_block_index[7:0] <= ram_q;
        default: if (last && ram_q != BYTE_ETX) bad <= 1'b1;
      endcase
      if (last && ram_q != BYTE_ETX) bad <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // validity of type, function, unit and layout
  logic [3:0] ctl;
  logic [3:0] drv;
  logic       pair_ok;
  logic       unit_ok;
  logic       pkt_ok;
  logic       is_test;
  logic       is_floppy;
  logic       is_tape;
  assign ctl       = unit[7:4];
  assign drv       = unit[3:0];
  assign is_config = ctype == TYPE_HALT && func == FUNC_CONFIG;
  assign is_test   = ctype == TYPE_TEST && func == FUNC_SELFTEST;
  assign is_floppy = ctl == 4'h0 && drv >= 4'h4 && drv <= 4'h7 && !is_tape;
  assign is_tape   = i_tape_fitted && ctl == 4'h0 && drv == 4'h4;
  always_comb begin
    case (ctype)
      TYPE_READ:  pair_ok = func == 8'h01;
      TYPE_WRITE: pair_ok = func == 8'h02;
      TYPE_TEST:  pair_ok = func == 8'h01 || func == 8'h02 || is_test;
      TYPE_CTRL:  pair_ok = func == 8'h01 || func == 8'h02;
      TYPE_HALT:  pair_ok = is_config;
      default:    pair_ok = 1'b0;
    endcase
  end
  assign unit_ok = (is_config || is_test) ? unit == 8'h00
                 : ((ctl <= 4'h7 && drv <= 4'h1) || is_floppy || is_tape)
                   && !(i_tape_fitted && ctl == 4'h0 && drv == 4'h5);
  assign pkt_ok  = !bad && pair_ok && unit_ok
                 && (!is_config || size == SIZE_CONFIG - 8'h01)
                 && (!is_test || size == SIZE_SELFTEST - 8'h01);

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  logic [1:0] stage;
  logic [2:0] results;
  logic       ctrl_seen;
  logic [7:0] sts_code;
  logic [7:0] sts_detail;
  assign take_cmd = state == ST_CHECK;
  assign post_ack = state == ST_CHECK && !simple_proto;
  assign ack_val  = pkt_ok ? FLAG_ACK : FLAG_NAK;
  assign post_sts = state == ST_POST && sts_posted == FLAG_CLEAR;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE; stage <= 2'd0; results <= 3'b000; ctrl_seen <= 1'b0;
      sts_code <= STS_OK; sts_detail <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: if (cmd_posted == FLAG_POSTED) state <= ST_FETCH;
        ST_FETCH: if (last) state <= ST_CHECK;
        ST_CHECK: begin
          sts_code   <= pkt_ok ? STS_OK : STS_INVALID;
          sts_detail <= 8'h00;
          if (!pkt_ok) state <= simple_proto ? ST_POST : ST_IDLE;
          else state <= ST_EXEC;
        end
        ST_EXEC: begin
          stage <= 2'd0;
          results <= 3'b000;
          if (is_config) state <= ST_POST;
          else if (is_test) state <= ST_TEST;
          else state <= ST_WAIT_OP;
        end
        ST_TEST: if (i_test_done) begin
          results[stage] <= i_test_pass;
          if (stage == 2'd1) ctrl_seen <= i_ctrl_present;
          if (stage == 2'd2 || (stage == 2'd1 && !i_ctrl_present)) begin
            sts_detail <= {5'h00, stage == 2'd2 ? i_test_pass : 1'b0,
                           stage == 2'd1 ? i_test_pass : results[1], results[0]};
            state <= ST_POST;
          end else stage <= stage + 2'd1;
        end
        ST_WAIT_OP: if (i_op_done) begin
          sts_detail <= i_op_status;
          state <= ST_POST;
        end
        ST_POST: if (post_sts) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // test request pulses on entry to each stage
  logic test_busy;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) test_busy <= 1'b0;
    else test_busy <= state == ST_TEST && !i_test_done;
  end
  assign o_test_req    = state == ST_TEST && !test_busy;
  assign o_test_stage  = stage;
  assign o_diag_opcode = stage == 2'd2 && ctrl_seen ? DIAG_OPCODE : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // configuration
  logic [7:0] cfg_vec;
  logic [7:0] cfg_attr;
  assign cfg_vec  = count[15:8];
  assign cfg_attr = count[7:0];
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      vector <= RST_VECTOR; simple_proto <= RST_SIMPLE; configured <= 1'b0;
    end else if (state == ST_EXEC && is_config) begin
      vector       <= cfg_vec;
      simple_proto <= cfg_attr[ATTR_PROTO_BIT];
      configured   <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // operation outputs
  logic [3:0] fsel;
  always_comb begin
    fsel = 4'h0;
    if (is_tape) fsel = 4'h3;
    else if (is_floppy) fsel[drv[1:0]] = 1'b1;
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_op_start <= 1'b0; o_op_type <= 8'h00; o_op_func <= 8'h00;
      o_op_count <= 16'h0000; o_op_block_size <= 16'h0000; o_op_am <= AM_DEFAULT;
      o_op_addr <= 24'h000000; o_disk_target <= 3'h0; o_disk_lun <= 1'b0;
      o_floppy_drive_select_n <= 4'hf; o_side_select_n <= 1'b1;
      o_disk_sector <= 21'h000000; o_fd_cylinder <= 8'h00; o_fd_sector <= 8'h00;
      o_tp_stream <= 8'h00; o_tp_segment <= 8'h00; o_tp_sector <= 8'h00;
    end else begin
      o_op_start <= state == ST_EXEC && !is_config && !is_test;
      if (state == ST_EXEC && !is_config && !is_test) begin
        o_op_type  <= ctype;
        o_op_func  <= func;
        o_op_count <= count;
        o_op_block_size <= bsize;
        o_op_am    <= (am_raw & AM_MAX) == AM_ZERO ? AM_DEFAULT : am_raw & AM_MAX;
        o_op_addr  <= {maddr[23:1], 1'b0};
        o_disk_target <= ctl[2:0];
        o_disk_lun    <= drv[0];
        o_floppy_drive_select_n <= ~fsel;
        o_side_select_n <= is_tape ? !linear_block_index[TP_SPS_LOG2 + TP_SEGS_LOG2]
                         : !(is_floppy && linear_block_index[FD_SPT_LOG2]);
        o_disk_sector <= linear_block_index[20:0];
        o_fd_sector   <= 8'(linear_block_index[FD_SPT_LOG2-1:0]);
        o_fd_cylinder <= 8'(linear_block_index >> (FD_SPT_LOG2 + 1));
        o_tp_sector   <= 8'(linear_block_index[TP_SPS_LOG2-1:0]);
        o_tp_segment  <= 8'(linear_block_index[TP_SPS_LOG2 + TP_SEGS_LOG2 - 1:TP_SPS_LOG2]);
        o_tp_stream   <= 8'(linear_block_index >> (TP_SPS_LOG2 + TP_SEGS_LOG2));
      end else if (state == ST_IDLE) begin
        o_floppy_drive_select_n <= 4'hf;
        o_side_select_n <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status message buffer and read mux
  logic [7:0] sts_byte;
  always_comb begin
    case (sts_idx)
      6'd0: sts_byte = BYTE_STX;
      6'd1: sts_byte = msg_id;
      6'd2: sts_byte = STS_SIZE;
      6'd3: sts_byte = unit;
      6'd4: sts_byte = sts_code;
      6'd5: sts_byte = sts_detail;
      6'd6: sts_byte = BYTE_ETX;
      default: sts_byte = 8'h00;
    endcase
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) o_prdata <= 32'h00000000;
    else if (i_psel && i_penable && !acc_wait) begin
      if (in_cmd_buf) o_prdata <= {24'h000000, ram_q};
      else if (in_sts_buf) o_prdata <= {24'h000000, sts_byte};
      else case (off)
        OFF_CMD_POSTED: o_prdata <= {24'h000000, cmd_posted};
        OFF_MSG_ACK:    o_prdata <= {24'h000000, msg_ack};
        OFF_STS_POSTED: o_prdata <= {24'h000000, sts_posted};
        OFF_CMD_CHECK:  o_prdata <= {24'h000000, cmd_check};
        OFF_VECTOR:     o_prdata <= {24'h000000, vector};
        OFF_STATE:      o_prdata <= {29'h00000000, o_irq, simple_proto, configured};
        default:        o_prdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== inc/dtc_pkg.sv ====
package dtc_pkg;
  // channel offsets (byte index, bus address is four times)
  localparam logic [9:0] OFF_CMD_POSTED = 10'h101;
  localparam logic [9:0] OFF_MSG_ACK    = 10'h103;
  localparam logic [9:0] OFF_CMD_BUF_LO = 10'h105;
  localparam logic [9:0] OFF_CMD_BUF_HI = 10'h17f;
  localparam logic [9:0] OFF_STS_POSTED = 10'h181;
  localparam logic [9:0] OFF_CMD_CHECK  = 10'h183;
  localparam logic [9:0] OFF_STS_BUF_LO = 10'h185;
  localparam logic [9:0] OFF_STS_BUF_HI = 10'h1ff;
  localparam logic [9:0] OFF_VECTOR     = 10'h102;
  localparam logic [9:0] OFF_STATE      = 10'h104;
  // packet marks and flag values
  localparam logic [7:0] BYTE_STX    = 8'h02;
  localparam logic [7:0] BYTE_ETX    = 8'h03;
  localparam logic [7:0] FLAG_POSTED = 8'h80;
  localparam logic [7:0] FLAG_CLEAR  = 8'h00;
  localparam logic [7:0] FLAG_ACK    = 8'h06;
  localparam logic [7:0] FLAG_NAK    = 8'h15;
  // command types and functions
  localparam logic [7:0] TYPE_READ  = 8'h10;
  localparam logic [7:0] TYPE_WRITE = 8'h20;
  localparam logic [7:0] TYPE_TEST  = 8'h30;
  localparam logic [7:0] TYPE_CTRL  = 8'h40;
  localparam logic [7:0] TYPE_HALT  = 8'h50;
  localparam logic [7:0] FUNC_CONFIG   = 8'h00;
  localparam logic [7:0] FUNC_SELFTEST = 8'hff;
  localparam logic [7:0] SIZE_CONFIG   = 8'h1d;
  localparam logic [7:0] SIZE_SELFTEST = 8'h07;
  localparam logic [7:0] SIZE_VERIFY   = 8'h0f;
  localparam logic [7:0] SIZE_MIN      = 8'h07;
  localparam logic [7:0] SIZE_MAX      = 8'h1d;
  localparam int         ATTR_PROTO_BIT = 7;
  // memory access
  localparam logic [7:0] AM_ZERO    = 8'h00;
  localparam logic [7:0] AM_DEFAULT = 8'h3e;
  localparam logic [7:0] AM_MAX     = 8'h3f;
  localparam logic [7:0] DIAG_OPCODE = 8'h04;
  // status message
  localparam logic [7:0] STS_SIZE    = 8'h07;
  localparam logic [7:0] STS_OK      = 8'h00;
  localparam logic [7:0] STS_INVALID = 8'h01;
  localparam logic [7:0] RST_VECTOR  = 8'h00;
  localparam logic       RST_SIMPLE  = 1'b0;
  typedef enum {ST_IDLE, ST_FETCH, ST_CHECK, ST_ACK, ST_EXEC, ST_TEST,
                ST_WAIT_OP, ST_POST} dtc_state_t;
endpackage

// ==== src/dtc_cmd_ram.sv ====
`timescale 1ns/100ps
`default_nettype none
module dtc_cmd_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // clock
  input  wire logic                     i_clock,
  // write port
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  // read port
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic      [WIDTH-1:0]         o_rdata
);
  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("dtc_cmd_ram: bad size");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge i_clock) begin
    if (i_we) mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// ==== tb/dtc_decoder_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module dtc_decoder_chk (
  // watched ports
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       i_psel,
  input wire logic       i_penable,
  input wire logic       i_iack,
  input wire logic       o_pready,
  input wire logic       o_pslverr,
  input wire logic       o_irq,
  input wire logic [3:0] o_floppy_drive_select_n,
  input wire logic       o_op_start,
  input wire logic [7:0] o_op_type,
  input wire logic [7:0] o_op_am,
  input wire logic       o_test_req,
  input wire logic [1:0] o_test_stage,
  input wire logic [7:0] o_diag_opcode
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  ready_one_wait_a: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
    else $error("pready not in second access cycle");
  ready_in_access_a: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  slverr_ready_a: assert property (o_pslverr |-> o_pready) else $error("pslverr without pready");
  am_range_a: assert property (o_op_start |-> o_op_am inside {[8'h01:8'h3f]})
    else $error("modifier out of range");
  op_type_a: assert property (o_op_start |-> o_op_type inside {8'h10, 8'h20, 8'h30, 8'h40, 8'h50})
    else $error("unknown type started");
  drive_select_a: assert property (~o_floppy_drive_select_n inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3})
    else $error("bad drive select pattern");
  diag_stage_a: assert property (o_test_req && o_test_stage == 2'd2 |-> o_diag_opcode == 8'h04)
    else $error("diagnostics opcode wrong");
  irq_hold_a: assert property (o_irq && !i_iack |=> o_irq)
    else $error("irq dropped without acknowledge");
endmodule
bind dtc_decoder dtc_decoder_chk i_chk (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_iack(i_iack), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_irq(o_irq), .o_floppy_drive_select_n(o_floppy_drive_select_n), .o_op_start(o_op_start),
  .o_op_type(o_op_type), .o_op_am(o_op_am), .o_test_req(o_test_req),
  .o_test_stage(o_test_stage), .o_diag_opcode(o_diag_opcode));
`default_nettype wire

// ==== tb/dtc_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dtc_far_model import dtc_pkg::*; (
  // requests
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_op_start,
  input  wire logic       i_test_req,
  input  wire logic [3:0] i_delay,
  // answers
  output logic            o_op_done,
  output logic      [7:0] o_op_status,
  output logic            o_test_done
);
  logic [3:0] cnt;
  logic       busy;
  logic       kind;
  // pace is set per command so the bench sees prompt and slow answers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 4'h0;
      busy <= 1'b0;
      kind <= 1'b0;
      o_op_done <= 1'b0;
      o_test_done <= 1'b0;
      o_op_status <= 8'h00;
    end else begin
      o_op_done <= busy && cnt == 4'h0 && !kind;
      o_test_done <= busy && cnt == 4'h0 && kind;
      // status is only meaningful with done, so it never rests elsewhere
      o_op_status <= (busy && cnt == 4'h0) ? STS_OK : ~o_op_status;
      if (i_op_start || i_test_req) begin
        busy <= 1'b1;
        kind <= i_test_req;
        cnt <= i_delay;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else begin
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/disk_tape_command_packet_decoder_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module disk_tape_command_packet_decoder_test;
  import dtc_pkg::*;
  logic        i_clock = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, iack = 0, tape = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0]  vec, am, cam, ost, vid, amv, pk[$];
  logic [3:0]  fsel, cfsel, exs, dly = 0;
  logic        pready, err, slverr, irq, ops, treq, opd, tdone;
  int          seed = 52, failures = 0, n_compared = 0, n, bad[4] = '{0, 2, 6, 4};
  always #50 i_clock = ~i_clock;
  dtc_decoder i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(slverr), .i_iack(iack), .o_irq(irq), .o_irq_vector(vec), .i_tape_fitted(tape),
    .o_floppy_drive_select_n(fsel), .o_side_select_n(), .o_disk_target(), .o_disk_lun(),
    .o_op_start(ops), .o_op_type(), .o_op_func(), .o_op_count(), .o_op_block_size(),
    .o_op_am(am), .o_op_addr(), .o_disk_sector(), .o_fd_cylinder(), .o_fd_sector(),
    .o_tp_stream(), .o_tp_segment(), .o_tp_sector(), .i_op_done(opd), .i_op_status(ost),
    .o_test_req(treq), .o_test_stage(), .o_diag_opcode(), .i_test_done(tdone),
    .i_test_pass(1'b1), .i_ctrl_present(1'b1));
  dtc_far_model i_far (.i_clock(i_clock), .i_rst(i_rst), .i_op_start(ops), .i_test_req(treq),
    .i_delay(dly), .o_op_done(opd), .o_op_status(ost), .o_test_done(tdone));
  always @(posedge i_clock) if (ops) begin
    cam <= am;
    cfsel <= fsel;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ready sampled at the rising edge; all inputs move by nba, so no race
  task automatic apb(input logic w, input logic [9:0] off, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= {off, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge i_clock);
    pen <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1 && ++k < 20);
    if (k == 20) failures++;
    rd = prdata;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic send(input logic [7:0] ack);
    foreach (pk[k]) apb(1'b1, OFF_CMD_BUF_LO + 10'(2 * k), pk[k]);
    apb(1'b1, OFF_CMD_POSTED, FLAG_POSTED);
    n = 0;
    do apb(1'b0, OFF_CMD_CHECK, 8'h00); while (rd[7:0] === FLAG_CLEAR && ++n < 60);
    chk(rd[7:0], ack);
    apb(1'b1, OFF_CMD_CHECK, FLAG_CLEAR);
  endtask
  task automatic get_sts(input logic [7:0] id);
    n = 0;
    do apb(1'b0, OFF_STS_POSTED, 8'h00); while (rd[7:0] !== FLAG_POSTED && ++n < 60);
    if (n == 60) failures++;
    apb(1'b0, OFF_STS_BUF_LO + 10'h2, 8'h00);
    chk(rd[7:0], id);
    apb(1'b0, OFF_STS_BUF_LO + 10'h8, 8'h00);
    chk(rd[7:0], STS_OK);
    apb(1'b1, OFF_STS_POSTED, FLAG_CLEAR);
    apb(1'b0, OFF_STS_BUF_LO + 10'ha, 8'h00);
  endtask
  task automatic ack_irq(input logic exp);
    chk(8'(irq), 8'(exp));
    iack <= 1'b1;
    @(posedge i_clock);
    iack <= 1'b0;
    @(posedge i_clock);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    apb(1'b0, OFF_STS_POSTED, 8'h00);
    chk(rd[7:0], FLAG_CLEAR);
    apb(1'b0, 10'h000, 8'h00);
    chk(8'(err), 8'h01);
    chk(8'(fsel), 8'h0f);
    $display("test reset done");
    vid = 8'($random(seed));
    pk = {BYTE_STX, 8'h5a, SIZE_CONFIG, 8'h00, TYPE_HALT, FUNC_CONFIG, vid, 8'h00};
    repeat (20) pk.push_back(8'h00);
    pk.push_back(BYTE_ETX);
    send(FLAG_ACK);
    get_sts(8'h5a);
    chk(vec, vid);
    ack_irq(1'b0);
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      pk = {BYTE_STX, 8'(i), SIZE_SELFTEST, 8'h00, TYPE_TEST, 8'h02, BYTE_ETX};
      pk[bad[i]] ^= 8'h41;
      send(FLAG_NAK);
      ack_irq(1'b1);
    end
    $display("test malformed done");
    for (int d = 4; d < 8; d++) begin
      amv = d == 4 ? AM_ZERO : 8'($random(seed)) & AM_MAX;
      dly <= 4'($random(seed));
      exs = ~(4'h1 << (d - 4));
      pk = {BYTE_STX, 8'(d), 8'h15, 8'(d), TYPE_READ, 8'h01, 8'h00, 8'h01};
      pk = {pk, 8'h02, 8'h00, amv, 8'h01, 8'h23, 8'h44};
      pk = {pk, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'(d), BYTE_ETX};
      send(FLAG_ACK);
      get_sts(8'(d));
      chk(cam, amv == AM_ZERO ? AM_DEFAULT : amv);
      chk(8'(cfsel), 8'(exs));
      ack_irq(1'b1);
    end
    tape <= 1'b1;
    pk[3] = 8'h05;
    send(FLAG_NAK);
    ack_irq(1'b1);
    pk[3] = 8'h04;
    send(FLAG_ACK);
    get_sts(8'h07);
    chk(8'(cfsel) & 8'h03, 8'h00);
    ack_irq(1'b1);
    $display("test drives done");
    pk = {BYTE_STX, 8'h77, SIZE_SELFTEST, 8'h00, TYPE_TEST, FUNC_SELFTEST, BYTE_ETX};
    send(FLAG_ACK);
    get_sts(8'h77);
    chk(rd[7:0], 8'h07);
    ack_irq(1'b1);
    $display("test selftest done");
    complete_run;
  end
  initial begin
    #3000000;
    failures++;
    complete_run;
  end
endmodule
`default_nettype wire
